// ---- design/acmc_pkg.sv ----
// constants and types for the converter operating-mode control
// Summary of operation
// - the three-bit mode setting is read-write and comes out of reset as zero, so continuous conversion is the default.
// - mode 000 converts again and again at the set rate, staying on one enabled channel or stepping through all enabled ones.
// - mode 001 converts the enabled channel once, or makes one pass over all enabled channels.
// - when the one-shot pass is over the converter drops to standby, code 010, with no further host write.
// - mode 011 powers every block down and the configuration counts as lost.
// - power-down is entered only when the mode just before it was standby, so the host selects standby first.
// - power-down is left only through a reset of the serial interface, which the host has to issue.
// - mode 110 takes the present input as the zero point and writes the result to that channel's offset coefficient.
// - a finished offset calibration moves the converter to standby, as after a one-shot pass.
// - full-scale calibration takes the present input as the full-scale point for the gain coefficient.
// - a finished full-scale calibration stores its coefficient in that channel's gain register, then goes to standby.
package acmc_pkg;

	////////////////////////////////////////////////////////////////////////
	localparam int MODE_W = 3;
	localparam int MODE_LSB = 4;
	localparam int MODE_MSB = 6;
	localparam int CFG_W = 16;
	localparam int DATA_W = 24;
	localparam int CH_IDX_W = 4;

	localparam logic [2:0] MODE_CONT = 3'h0;
	localparam logic [2:0] MODE_SINGLE = 3'h1;
	localparam logic [2:0] MODE_STBY = 3'h2;
	localparam logic [2:0] MODE_PDOWN = 3'h3;
	localparam logic [2:0] MODE_RSV_A = 3'h4;
	localparam logic [2:0] MODE_RSV_B = 3'h5;
	localparam logic [2:0] MODE_OFSCAL = 3'h6;
	localparam logic [2:0] MODE_GAINCAL = 3'h7;
	localparam logic [2:0] MODE_RST = MODE_CONT;

	////////////////////////////////////////////////////////////////////////
	typedef enum logic [5:0] {
		ST_CONT = 6'h01,
		ST_SINGLE = 6'h02,
		ST_STBY = 6'h04,
		ST_PDOWN = 6'h08,
		ST_OFSCAL = 6'h10,
		ST_GAINCAL = 6'h20
	} acmc_state_t;

	// one conversion or coefficient word with its channel
	typedef struct packed {
		logic valid;
		logic [CH_IDX_W-1:0] chan;
		logic [DATA_W-1:0] data;
	} acmc_word_t;

endpackage

// ---- design/acmc_tick_div.sv ----
// conversion-rate divider giving one-cycle enable pulses
`timescale 1ns/1ps
module acmc_tick_div #(
	parameter int W = 16
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic en,
	input wire logic clr,
	input wire logic [W-1:0] period,
	output logic tick
);

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	////////////////////////////////////////////////////////////////////////
	// a period of zero or one gives a tick on every cycle
	always_comb begin
		tick = en && !clr &&
			((period <= W'(1)) || (cnt_r == period - W'(1)));
		if (clr || !en || tick) begin
			cnt_nxt = '0;
		end else begin
			cnt_nxt = cnt_r + W'(1);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

endmodule

// ---- design/acmc_top.sv ----
// converter operating-mode control: mode field, sequencing, calibration
`timescale 1ns/1ps
module acmc_top #(
	parameter int NUM_CH = 4,
	parameter int DIV_W = 16
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic cfg_wr,
	input wire logic [acmc_pkg::CFG_W-1:0] cfg_wdata,
	input wire logic if_reset,
	input wire logic [NUM_CH-1:0] ch_enable,
	input wire logic [DIV_W-1:0] conv_period,
	input wire logic [acmc_pkg::DATA_W-1:0] sample_data,
	output logic [acmc_pkg::MODE_W-1:0] mode_code_r,
	output logic converting_r,
	output logic powered_down_r,
	output logic cfg_lost_r,
	output logic [acmc_pkg::CH_IDX_W-1:0] chan_r,
	output acmc_pkg::acmc_word_t result_r,
	output acmc_pkg::acmc_word_t ofs_wr_r,
	output acmc_pkg::acmc_word_t gain_wr_r
);

	////////////////////////////////////////////////////////////////////////
	// channel search helpers
	function automatic logic [acmc_pkg::CH_IDX_W-1:0] first_en(
		input logic [NUM_CH-1:0] en
	);
		logic [acmc_pkg::CH_IDX_W-1:0] idx;
		idx = '0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (en[i]) begin
				idx = acmc_pkg::CH_IDX_W'(i);
			end
		end
		return idx;
	endfunction

	// lowest enabled channel above cur; found low means cur was the last
	function automatic logic [acmc_pkg::CH_IDX_W:0] next_en(
		input logic [NUM_CH-1:0] en,
		input logic [acmc_pkg::CH_IDX_W-1:0] cur
	);
		logic [acmc_pkg::CH_IDX_W:0] res;
		res = '0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (en[i] && (i > int'(cur))) begin
				res = {1'b1, acmc_pkg::CH_IDX_W'(i)};
			end
		end
		return res;
	endfunction

	function automatic logic [2:0] code_of(input acmc_pkg::acmc_state_t s);
		case (s)
			acmc_pkg::ST_CONT: code_of = acmc_pkg::MODE_CONT;
			acmc_pkg::ST_SINGLE: code_of = acmc_pkg::MODE_SINGLE;
			acmc_pkg::ST_STBY: code_of = acmc_pkg::MODE_STBY;
			acmc_pkg::ST_PDOWN: code_of = acmc_pkg::MODE_PDOWN;
			acmc_pkg::ST_OFSCAL: code_of = acmc_pkg::MODE_OFSCAL;
			acmc_pkg::ST_GAINCAL: code_of = acmc_pkg::MODE_GAINCAL;
			default: code_of = acmc_pkg::MODE_RST;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	acmc_pkg::acmc_state_t state_r;
	acmc_pkg::acmc_state_t state_nxt;
	logic [acmc_pkg::CH_IDX_W-1:0] chan_nxt;
	logic [acmc_pkg::MODE_W-1:0] mode_code_nxt;
	logic converting_nxt;
	logic powered_down_nxt;
	logic cfg_lost_nxt;
	acmc_pkg::acmc_word_t result_nxt;
	acmc_pkg::acmc_word_t ofs_wr_nxt;
	acmc_pkg::acmc_word_t gain_wr_nxt;
	logic [acmc_pkg::MODE_W-1:0] wr_mode;
	logic [acmc_pkg::CH_IDX_W-1:0] first_ch;
	logic [acmc_pkg::CH_IDX_W:0] next_ch;
	logic any_en;
	logic run;
	logic restart;
	logic tick;

	assign wr_mode = cfg_wdata[acmc_pkg::MODE_MSB:acmc_pkg::MODE_LSB];
	assign first_ch = first_en(ch_enable);
	assign next_ch = next_en(ch_enable, chan_r);
	assign any_en = |ch_enable;
	// no enabled channel means nothing to convert, so the rate stops
	assign run = any_en && converting_r;
	assign restart = if_reset || (cfg_wr && (state_r != acmc_pkg::ST_PDOWN));

	acmc_tick_div #(
		.W(DIV_W)
	) u_rate (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.en(run),
		.clr(restart),
		.period(conv_period),
		.tick(tick)
	);

	////////////////////////////////////////////////////////////////////////
	// mode sequencing; a host write that selects a mode beats an automatic drop to standby
	always_comb begin
		state_nxt = state_r;
		chan_nxt = chan_r;
		result_nxt = '0;
		ofs_wr_nxt = '0;
		gain_wr_nxt = '0;
		case (state_r)
			acmc_pkg::ST_CONT: begin
				if (tick) begin
					result_nxt = {1'b1, chan_r, sample_data};
					chan_nxt = next_ch[acmc_pkg::CH_IDX_W] ?
						next_ch[acmc_pkg::CH_IDX_W-1:0] : first_ch;
				end
			end
			acmc_pkg::ST_SINGLE: begin
				if (tick) begin
					result_nxt = {1'b1, chan_r, sample_data};
					if (next_ch[acmc_pkg::CH_IDX_W]) begin
						chan_nxt = next_ch[acmc_pkg::CH_IDX_W-1:0];
					end else begin
						state_nxt = acmc_pkg::ST_STBY;
					end
				end
			end
			acmc_pkg::ST_OFSCAL: begin
				if (tick) begin
					ofs_wr_nxt = {1'b1, chan_r, sample_data};
					state_nxt = acmc_pkg::ST_STBY;
				end
			end
			acmc_pkg::ST_GAINCAL: begin
				if (tick) begin
					gain_wr_nxt = {1'b1, chan_r, sample_data};
					state_nxt = acmc_pkg::ST_STBY;
				end
			end
			acmc_pkg::ST_STBY: begin
			end
			acmc_pkg::ST_PDOWN: begin
			end
			default: begin
				state_nxt = acmc_pkg::ST_CONT;
			end
		endcase
		// writes are ignored while powered down
		if (cfg_wr && (state_r != acmc_pkg::ST_PDOWN)) begin
			chan_nxt = first_ch;
			case (wr_mode)
				acmc_pkg::MODE_CONT: begin
					state_nxt = acmc_pkg::ST_CONT;
				end
				acmc_pkg::MODE_SINGLE: begin
					state_nxt = acmc_pkg::ST_SINGLE;
				end
				acmc_pkg::MODE_STBY: begin
					state_nxt = acmc_pkg::ST_STBY;
				end
				acmc_pkg::MODE_PDOWN: begin
					if (state_r == acmc_pkg::ST_STBY) begin
						state_nxt = acmc_pkg::ST_PDOWN;
					end
				end
				acmc_pkg::MODE_OFSCAL: begin
					state_nxt = acmc_pkg::ST_OFSCAL;
				end
				acmc_pkg::MODE_GAINCAL: begin
					state_nxt = acmc_pkg::ST_GAINCAL;
				end
				default: begin
					chan_nxt = chan_r;
				end
			endcase
		end
		// interface reset is the only way out of power-down
		if (if_reset) begin
			state_nxt = acmc_pkg::ST_CONT;
			chan_nxt = first_ch;
		end
		mode_code_nxt = code_of(state_nxt);
		converting_nxt = (state_nxt == acmc_pkg::ST_CONT) ||
			(state_nxt == acmc_pkg::ST_SINGLE) ||
			(state_nxt == acmc_pkg::ST_OFSCAL) ||
			(state_nxt == acmc_pkg::ST_GAINCAL);
		powered_down_nxt = (state_nxt == acmc_pkg::ST_PDOWN);
		cfg_lost_nxt = (state_nxt == acmc_pkg::ST_PDOWN) &&
			(state_r != acmc_pkg::ST_PDOWN);
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_r <= acmc_pkg::ST_CONT;
			chan_r <= '0;
			mode_code_r <= acmc_pkg::MODE_RST;
			converting_r <= 1'b1;
			powered_down_r <= 1'b0;
			cfg_lost_r <= 1'b0;
			result_r <= '0;
			ofs_wr_r <= '0;
			gain_wr_r <= '0;
		end else begin
			state_r <= state_nxt;
			chan_r <= chan_nxt;
			mode_code_r <= mode_code_nxt;
			converting_r <= converting_nxt;
			powered_down_r <= powered_down_nxt;
			cfg_lost_r <= cfg_lost_nxt;
			result_r <= result_nxt;
			ofs_wr_r <= ofs_wr_nxt;
			gain_wr_r <= gain_wr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_pass_end;
		(state_r == acmc_pkg::ST_SINGLE) && tick &&
			!next_ch[acmc_pkg::CH_IDX_W] && !cfg_wr && !if_reset;
	endsequence

	sequence s_pass_step;
		(state_r == acmc_pkg::ST_SINGLE) && tick &&
			next_ch[acmc_pkg::CH_IDX_W] && !cfg_wr && !if_reset;
	endsequence

	sequence s_cal_end(acmc_pkg::acmc_state_t s);
		(state_r == s) && tick && !cfg_wr && !if_reset;
	endsequence

	AST_RESET_MODE: assert property (@(posedge clk_sys)
		sys_rst |=> (mode_code_r == 3'h0) && (state_r == acmc_pkg::ST_CONT))
		else $error("mode not continuous after reset");

	AST_CONT_RUNS: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		(state_r == acmc_pkg::ST_CONT) && tick && !cfg_wr && !if_reset
		|=> result_r.valid && (state_r == acmc_pkg::ST_CONT)
			&& (result_r.chan == $past(chan_r)))
		else $error("continuous conversion lost");

	AST_SINGLE_STBY: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		s_pass_end |=> result_r.valid && (mode_code_r == 3'h2))
		else $error("one-shot pass did not end in standby");

	AST_PD_FROM_STBY: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		$rose(powered_down_r) |-> $past(state_r) == acmc_pkg::ST_STBY)
		else $error("power-down entered from a mode other than standby");

	AST_PD_LOST: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		$rose(powered_down_r) |-> cfg_lost_r && !converting_r
			&& (mode_code_r == 3'h3))
		else $error("power-down without configuration loss");

	AST_PD_HOLD: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		powered_down_r && !if_reset |=> powered_down_r)
		else $error("power-down left without interface reset");

	AST_PD_EXIT: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		powered_down_r && if_reset |=> !powered_down_r
			&& (mode_code_r == 3'h0))
		else $error("interface reset did not leave power-down");

	AST_OFS_CAL: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		s_cal_end(acmc_pkg::ST_OFSCAL) |=> ofs_wr_r.valid
			&& !gain_wr_r.valid && (state_r == acmc_pkg::ST_STBY))
		else $error("offset calibration did not store and stop");

	AST_GAIN_CAL: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		s_cal_end(acmc_pkg::ST_GAINCAL) |=> gain_wr_r.valid
			&& (gain_wr_r.data == $past(sample_data))
			&& (state_r == acmc_pkg::ST_STBY))
		else $error("gain calibration did not store and stop");

	AST_GAIN_CODE: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		cfg_wr && !if_reset && !powered_down_r && (wr_mode == 3'h7)
		|=> (state_r == acmc_pkg::ST_GAINCAL) && (mode_code_r == 3'h7))
		else $error("code 111 did not select full-scale calibration");

	AST_RSVD_KEEP: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		cfg_wr && !if_reset && !tick && ((wr_mode == 3'h4) || (wr_mode == 3'h5))
		|=> $stable(mode_code_r))
		else $error("reserved code changed the mode");

	AST_SINGLE_STEP: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		s_pass_step |=> result_r.valid && (state_r == acmc_pkg::ST_SINGLE)
			&& (chan_r == $past(next_ch[acmc_pkg::CH_IDX_W-1:0])))
		else $error("one-shot pass did not step to the next channel");

	// nothing may convert or store while the blocks are off
	AST_PD_QUIET: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		powered_down_r |-> !converting_r && !result_r.valid
			&& !ofs_wr_r.valid && !gain_wr_r.valid)
		else $error("activity while powered down");

endmodule

// ---- verification/acmc_host_model.sv ----
// host model: writes the mode field and issues serial-interface resets
`timescale 1ns/1ps
module acmc_host_model (
	input wire logic clk_sys,
	output logic cfg_wr,
	output logic [acmc_pkg::CFG_W-1:0] cfg_wdata,
	output logic if_reset
);
	////////////////////////////////////////////////////////////////////////
	logic [2:0] last_code;

	initial begin
		cfg_wr = 1'b0;
		cfg_wdata = 16'h0000;
		if_reset = 1'b0;
		last_code = acmc_pkg::MODE_RST;
	end

	// one-cycle strobe; also used by the bench to break host rules on purpose
	task automatic raw_write(input logic [2:0] code);
		@(negedge clk_sys);
		cfg_wr = 1'b1;
		cfg_wdata = {9'h000, code, 4'h0};
		@(negedge clk_sys);
		cfg_wr = 1'b0;
		last_code = code;
	endtask

	task automatic write_mode(input logic [2:0] code);
		// reserved codes are simply never sent
		if (code == acmc_pkg::MODE_RSV_A || code == acmc_pkg::MODE_RSV_B) begin
			return;
		end
		// standby always precedes power-down
		if (code == acmc_pkg::MODE_PDOWN && last_code != acmc_pkg::MODE_STBY) begin
			raw_write(acmc_pkg::MODE_STBY);
		end
		raw_write(code);
	endtask

	// the only way out of power-down
	task automatic iface_reset();
		@(negedge clk_sys);
		if_reset = 1'b1;
		@(negedge clk_sys);
		if_reset = 1'b0;
		last_code = acmc_pkg::MODE_RST;
	endtask
endmodule

// ---- verification/acmc_top_tb.sv ----
// self-checking bench for the converter operating-mode control
`timescale 1ns/1ps
module acmc_top_tb;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic cfg_wr;
	logic [acmc_pkg::CFG_W-1:0] cfg_wdata;
	logic if_reset;
	logic [3:0] ch_enable = 4'h0;
	logic [15:0] conv_period = 16'h0002;
	logic [acmc_pkg::DATA_W-1:0] sample_data = 24'h000000;
	logic [2:0] mode_code_r;
	logic converting_r;
	logic powered_down_r;
	logic cfg_lost_r;
	logic [3:0] chan_r;
	acmc_pkg::acmc_word_t result_r;
	acmc_pkg::acmc_word_t ofs_wr_r;
	acmc_pkg::acmc_word_t gain_wr_r;
	int err_total = 0;
	int check_count = 0;
	int cycles = 0;

	always #2 clk_sys = ~clk_sys;

	acmc_top uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_wr(cfg_wr),
		.cfg_wdata(cfg_wdata), .if_reset(if_reset), .ch_enable(ch_enable),
		.conv_period(conv_period), .sample_data(sample_data),
		.mode_code_r(mode_code_r), .converting_r(converting_r),
		.powered_down_r(powered_down_r), .cfg_lost_r(cfg_lost_r),
		.chan_r(chan_r), .result_r(result_r), .ofs_wr_r(ofs_wr_r),
		.gain_wr_r(gain_wr_r));

	acmc_host_model host (.clk_sys(clk_sys), .cfg_wr(cfg_wr),
		.cfg_wdata(cfg_wdata), .if_reset(if_reset));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic acmc_pkg::acmc_word_t pick(input int sel);
		return (sel == 0) ? result_r : (sel == 1) ? ofs_wr_r : gain_wr_r;
	endfunction

	// bounded wait for a valid pulse on the chosen word, mode taken alongside
	task automatic wait_word(input int sel, output acmc_pkg::acmc_word_t w,
		output logic [2:0] m);
		acmc_pkg::acmc_word_t t;
		w = '0;
		m = 3'h0;
		for (int i = 0; i < 50; i++) begin
			@(negedge clk_sys);
			t = pick(sel);
			if (t.valid === 1'b1) begin
				w = t;
				m = mode_code_r;
				return;
			end
		end
		check("word valid", 32'h0, 32'h1);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// whole run needs well under a thousand cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		acmc_pkg::acmc_word_t w;
		logic [2:0] m;
		logic [3:0] exp_ch[5];
		logic [23:0] cal_data[4];
		int extra;
		exp_ch = '{4'h0, 4'h1, 4'h3, 4'h0, 4'h1};
		cal_data = '{24'h00f00d, 24'h7e0421, 24'h013570, 24'h6cc2a9};
		repeat (3) @(negedge clk_sys);
		sys_rst = 1'b0;
		check("reset mode", mode_code_r, 32'h0);
		check("reset converting", converting_r, 32'h1);
		check("reset powered down", powered_down_r, 32'h0);
		$display("test reset done");

		ch_enable = 4'hb;
		sample_data = 24'h5a1c33;
		host.write_mode(acmc_pkg::MODE_CONT);
		for (int i = 0; i < 5; i++) begin
			wait_word(0, w, m);
			check("cont chan", w.chan, exp_ch[i]);
			check("cont data", w.data, sample_data);
		end
		$display("test continuous done");

		// ascending single pass over channels 0 and 2, then standby
		ch_enable = 4'h5;
		host.write_mode(acmc_pkg::MODE_SINGLE);
		wait_word(0, w, m);
		check("single chan a", w.chan, 32'h0);
		wait_word(0, w, m);
		check("single chan b", w.chan, 32'h2);
		check("single end mode", m, acmc_pkg::MODE_STBY);
		extra = 0;
		repeat (20) begin
			@(negedge clk_sys);
			if (result_r.valid !== 1'b0) extra++;
		end
		check("single extra results", extra, 32'h0);
		check("single converting", converting_r, 32'h0);
		$display("test single done");

		// device tolerance of host mistakes: reserved code, power-down order
		host.raw_write(acmc_pkg::MODE_RSV_A);
		check("reserved a mode", mode_code_r, acmc_pkg::MODE_STBY);
		host.raw_write(acmc_pkg::MODE_RSV_B);
		check("reserved b mode", mode_code_r, acmc_pkg::MODE_STBY);
		host.raw_write(acmc_pkg::MODE_CONT);
		host.raw_write(acmc_pkg::MODE_PDOWN);
		check("pdown refused", mode_code_r, acmc_pkg::MODE_CONT);
		check("pdown refused flag", powered_down_r, 32'h0);
		host.write_mode(acmc_pkg::MODE_PDOWN);
		check("pdown mode", mode_code_r, acmc_pkg::MODE_PDOWN);
		check("pdown flag", powered_down_r, 32'h1);
		check("cfg lost pulse", cfg_lost_r, 32'h1);
		check("pdown converting", converting_r, 32'h0);
		@(negedge clk_sys);
		check("cfg lost end", cfg_lost_r, 32'h0);
		host.raw_write(acmc_pkg::MODE_CONT);
		check("pdown holds", mode_code_r, acmc_pkg::MODE_PDOWN);
		host.iface_reset();
		check("exit mode", mode_code_r, acmc_pkg::MODE_CONT);
		check("exit flag", powered_down_r, 32'h0);
		check("exit converting", converting_r, 32'h1);
		$display("test power-down done");

		// one channel only while calibrating; the second pair stands for a
		// gain change, after which both coefficients are taken again
		ch_enable = 4'h4;
		for (int k = 0; k < 4; k++) begin
			sample_data = cal_data[k];
			host.write_mode(k[0] ? acmc_pkg::MODE_GAINCAL
				: acmc_pkg::MODE_OFSCAL);
			check("cal chan now", chan_r, 32'h2);
			wait_word(k[0] ? 2 : 1, w, m);
			check("cal chan", w.chan, 32'h2);
			check("cal data", w.data, sample_data);
			check("cal end mode", m, acmc_pkg::MODE_STBY);
		end
		$display("test calibration done");

		// reset again from standby: the default mode has to come back
		@(negedge clk_sys);
		sys_rst = 1'b1;
		repeat (2) @(negedge clk_sys);
		sys_rst = 1'b0;
		check("rerun mode", mode_code_r, 32'h0);
		check("rerun converting", converting_r, 32'h1);
		check("rerun chan", chan_r, 32'h0);
		$display("test second reset done");
		results();
	end
endmodule
